/* design/bab_pkg.sv */
// Package for the baseband / antenna / bias command handler.
// Assumes a single 200 MHz clock and a host-side parser that
// delivers already decoded commands as one struct per request.
package bab_pkg;

    // ------------------------------------------------------------
    // Channels, widths and limits
    // ------------------------------------------------------------
    localparam int                  CHAN_CNT       = 4;
    localparam logic [1:0]          CHAN_MAX       = 2'h3;
    localparam int                  SPI_MAX_BYTES  = 8;
    localparam logic [3:0]          SPI_MAX_CNT    = 4'h8;
    localparam logic [11:0]         DAC_RESET      = 12'h000;
    localparam logic [7:0]          FLT_RAW_RESET  = 8'h00;
    localparam logic [3:0]          LINES_RESET    = 4'h0;
    localparam logic [15:0]         CUR_LIMIT_DEF  = 16'h0800;

    // Antenna line bit positions
    localparam int                  LINE_RESET_POS = 0;
    localparam int                  LINE_TX_RX_SWITCH_LINE_POS  = 1;
    localparam int                  LINE_BEAM_POS  = 2;
    localparam int                  LINE_SPARE_POS = 3;

    // ------------------------------------------------------------
    // Serial clock timing: half period of the array serial clock
    // ------------------------------------------------------------
    localparam int                  SCK_HALF_NS    = 50;
    localparam int                  CLK_PERIOD_NS  = 5;
    localparam logic [7:0]          SCK_HALF_CYC   = 8'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Filter codes (same code in select and query)
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BAB_FLT_5     = 4'h0,
        BAB_FLT_10    = 4'h1,
        BAB_FLT_20    = 4'h2,
        BAB_FLT_30    = 4'h3,
        BAB_FLT_50    = 4'h4,
        BAB_FLT_100   = 4'h5,
        BAB_FLT_200   = 4'h6,
        BAB_FLT_BYP   = 4'h7
    } bab_flt_e;
    localparam logic [3:0]          FLT_CODE_MAX   = 4'h7;
    localparam logic [3:0]          FLT_CODE_RESET = 4'h7;

    // Command opcodes
    typedef enum logic [3:0] {
        BAB_OP_FLT_SEL    = 4'h0,
        BAB_OP_FLT_QRY    = 4'h1,
        BAB_OP_RAW_WR     = 4'h2,
        BAB_OP_RAW_RD     = 4'h3,
        BAB_OP_LINE_SET   = 4'h4,
        BAB_OP_LINE_QRY   = 4'h5,
        BAB_OP_SPI_XFER   = 4'h6,
        BAB_OP_LOOP       = 4'h7,
        BAB_OP_DAC_SET    = 4'h8,
        BAB_OP_DAC_QRY    = 4'h9,
        BAB_OP_CUR_SET    = 4'ha,
        BAB_OP_CUR_QRY    = 4'hb,
        BAB_OP_GATE_QRY   = 4'hc,
        BAB_OP_DRAIN_QRY  = 4'hd
    } bab_op_e;

    // Decoded command from the console parser
    typedef struct packed {
        bab_op_e            op;
        logic [2:0]         chan;       // Three bits so that 4..7 can be rejected
        logic               path_tx;    // Filter commands accept TX only
        logic [15:0]        value;      // Code, raw byte, DAC, loop flag or amps
        logic [3:0]         line_mask;  // Lines named in a line set command
        logic [3:0]         line_val;
        logic [3:0]         spi_cnt;    // Byte count of a serial transfer
        logic [63:0]        spi_data;   // Byte 0 in bits 7:0
    } bab_cmd_s;

    // Reply to the console formatter
    typedef struct packed {
        logic               ok;         // OK line follows the data
        logic               err;
        logic               has_data;
        logic [3:0]         spi_cnt;
        logic [63:0]        data;       // Query data or received bytes
    } bab_rsp_s;

    // Measured analog readings of one channel
    typedef struct packed {
        logic [15:0]        current;
        logic [15:0]        gate_volt;  // Signed, may be negative
        logic [15:0]        drain_volt;
    } bab_meas_s;

endpackage : bab_pkg

/* design/bab_cmd_check.sv */
// Range checker for decoded console commands.
// Assumes the command struct is stable while valid is high.
`timescale 1ns/1ps
module bab_cmd_check (
    // Command and limit
    input  wire bab_pkg::bab_cmd_s cmd_i,
    input  wire logic [15:0]       cur_limit_i,
    // Verdict
    output logic                   legal_o
);

    // ------------------------------------------------------------
    // Argument ranges per opcode
    // ------------------------------------------------------------
    always_comb
    begin
        legal_o = (cmd_i.chan <= 3'(bab_pkg::CHAN_MAX));
        case (cmd_i.op)
            bab_pkg::BAB_OP_FLT_SEL:
                legal_o = legal_o && cmd_i.path_tx && (cmd_i.value <= 16'(bab_pkg::FLT_CODE_MAX));
            bab_pkg::BAB_OP_FLT_QRY, bab_pkg::BAB_OP_RAW_RD:
                legal_o = legal_o && cmd_i.path_tx;
            bab_pkg::BAB_OP_RAW_WR:
                legal_o = legal_o && cmd_i.path_tx && (cmd_i.value[15:8] == 8'h00);
            bab_pkg::BAB_OP_LINE_SET:
                legal_o = legal_o && (cmd_i.line_mask != 4'h0);
            bab_pkg::BAB_OP_SPI_XFER:
                legal_o = legal_o && (cmd_i.spi_cnt != 4'h0) && (cmd_i.spi_cnt <= bab_pkg::SPI_MAX_CNT);
            bab_pkg::BAB_OP_LOOP:
                legal_o = legal_o && (cmd_i.value <= 16'h0001);
            bab_pkg::BAB_OP_DAC_SET:
                legal_o = legal_o && (cmd_i.value[15:12] == 4'h0);
            bab_pkg::BAB_OP_CUR_SET:
                legal_o = legal_o && (cmd_i.value <= cur_limit_i);
            bab_pkg::BAB_OP_LINE_QRY, bab_pkg::BAB_OP_DAC_QRY, bab_pkg::BAB_OP_CUR_QRY,
            bab_pkg::BAB_OP_GATE_QRY, bab_pkg::BAB_OP_DRAIN_QRY:
                legal_o = legal_o;
            default:
                legal_o = 1'b0;
        endcase
    end

endmodule : bab_cmd_check

/* design/bab_spi_shift.sv */
// Full-duplex byte shifter for the antenna-array serial bus, mode 0, MSB first.
// Assumes the miso pin has already passed two flip-flops.
`timescale 1ns/1ps
module bab_spi_shift (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // Request
    input  wire logic        start_i,
    input  wire logic [3:0]  cnt_i,
    input  wire logic [63:0] tx_i,
    // Result
    output logic             done_o,
    output logic [63:0]      rx_o,
    // Pins
    output logic             sck_o,
    output logic             cs_n_o,
    output logic             mosi_o,
    input  wire logic        miso_i
);

    logic [7:0]  tick_r;
    logic [6:0]  bits_r;
    logic [63:0] tx_r;
    logic        busy_r;
    logic [7:0]  rxb_r;
    logic [2:0]  byte_r;

    // ------------------------------------------------------------
    // Bit engine: shift out on falling, sample on rising edge
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        done_o <= 1'b0;
        if (sys_rst_i)
        begin
            busy_r <= 1'b0;
            sck_o  <= 1'b0;
            cs_n_o <= 1'b1;
            mosi_o <= 1'b0;
            tick_r <= 8'h00;
            bits_r <= 7'h00;
            tx_r   <= 64'h0;
            rx_o   <= 64'h0;
            rxb_r  <= 8'h00;
            byte_r <= 3'h0;
        end
        else if (start_i && !busy_r)
        begin
            busy_r <= 1'b1;
            cs_n_o <= 1'b0;
            bits_r <= 7'({cnt_i, 3'h0});
            tx_r   <= tx_i;
            mosi_o <= tx_i[7];
            rx_o   <= 64'h0;
            rxb_r  <= 8'h00;
            byte_r <= 3'h0;
            tick_r <= bab_pkg::SCK_HALF_CYC;
        end
        else if (busy_r)
        begin
            if (tick_r > 8'h01)
                tick_r <= tick_r - 8'h01;
            else
            begin
                tick_r <= bab_pkg::SCK_HALF_CYC;
                if (!sck_o)
                begin
                    sck_o <= 1'b1;
                    // Bits gather in a byte register, placed whole at byte end
                    rxb_r <= {rxb_r[6:0], miso_i};
                end
                else
                begin
                    sck_o  <= 1'b0;
                    bits_r <= bits_r - 7'h01;
                    if (bits_r[2:0] == 3'h1)
                    begin
                        tx_r   <= {8'h00, tx_r[63:8]};
                        // Byte k lands at rx[8k+7:8k], same slot as its tx byte
                        rx_o[{byte_r, 3'h0} +: 8] <= rxb_r;
                        byte_r <= byte_r + 3'h1;
                    end
                    else
                        tx_r <= {tx_r[63:8], tx_r[6:0], 1'b0};
                    if (bits_r == 7'h01)
                    begin
                        busy_r <= 1'b0;
                        cs_n_o <= 1'b1;
                        done_o <= 1'b1;
                    end
                    mosi_o <= (bits_r[2:0] == 3'h1) ? tx_r[15] : tx_r[6];
                end
            end
        end
    end

endmodule : bab_spi_shift

/* design/bab_cmd_top.sv */
// Console command engine for the TX baseband filter, antenna lines and PA bias.
// Assumes a parser on the same clock hands over one decoded command per pulse.
`timescale 1ns/1ps
module bab_cmd_top (
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  sys_rst_i,
    // Command side
    input  wire logic                  cmd_valid_i,
    input  wire bab_pkg::bab_cmd_s     cmd_i,
    input  wire logic [15:0]           cur_limit_i,
    output logic                       cmd_ready_o,
    // Response side
    output logic                       rsp_valid_o,
    output bab_pkg::bab_rsp_s          rsp_o,
    // Measurements per channel
    input  wire bab_pkg::bab_meas_s [3:0] meas_i,
    // Filter bank control byte per channel
    output logic [3:0][7:0]            filter_ctrl_o,
    // Antenna lines per channel: reset, tx/rx switch, beam, spare
    output logic [3:0][3:0]            array_line_o,
    // Bias loop per channel
    output logic [3:0]                 bias_loop_en_o,
    output logic [3:0][11:0]           bias_dac_o,
    output logic [3:0][15:0]           bias_amps_o,
    output logic [3:0]                 bias_amps_mode_o,
    // Antenna array serial bus
    output logic                       array_sck_o,
    output logic                       array_cs_n_o,
    output logic                       array_mosi_o,
    input  wire logic                  array_miso_i
);

    // ------------------------------------------------------------
    // Engine states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SPI  = 3'b010,
        ST_RSP  = 3'b100
    } bab_state_e;

    bab_state_e        state_r;
    bab_pkg::bab_cmd_s cmd_r;
    logic              legal;
    logic              take;
    logic [1:0]        ch;
    logic              miso_s1_r;
    logic              miso_s2_r;
    logic              spi_start_r;
    logic              spi_done;
    logic [63:0]       spi_rx;
    logic [3:0][3:0]   code_r;

    assign ch   = cmd_i.chan[1:0];
    assign take = cmd_valid_i && cmd_ready_o;

    // Argument checks live in one place so the bench can mirror them
    bab_cmd_check u_check (
        .cmd_i       (cmd_i),
        .cur_limit_i (cur_limit_i),
        .legal_o     (legal)
    );

    // Miso crosses in from the pin through two flops
    always_ff @(posedge core_clk_i)
    begin
        miso_s1_r <= array_miso_i;
        miso_s2_r <= miso_s1_r;
    end

    bab_spi_shift u_spi (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .start_i    (spi_start_r),
        .cnt_i      (cmd_r.spi_cnt),
        .tx_i       (cmd_r.spi_data),
        .done_o     (spi_done),
        .rx_o       (spi_rx),
        .sck_o      (array_sck_o),
        .cs_n_o     (array_cs_n_o),
        .mosi_o     (array_mosi_o),
        .miso_i     (miso_s2_r)
    );

    // ------------------------------------------------------------
    // Sequencing: one command at a time, ready drops until reply
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        spi_start_r <= 1'b0;
        if (sys_rst_i)
        begin
            state_r     <= ST_IDLE;
            cmd_ready_o <= 1'b0;
            cmd_r       <= '0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    cmd_ready_o <= 1'b1;
                    if (take)
                    begin
                        cmd_ready_o <= 1'b0;
                        cmd_r       <= cmd_i;
                        if (legal && cmd_i.op == bab_pkg::BAB_OP_SPI_XFER)
                        begin
                            spi_start_r <= 1'b1;
                            state_r     <= ST_SPI;
                        end
                        else
                            state_r <= ST_RSP;
                    end
                end
                ST_SPI:
                    if (spi_done)
                        state_r <= ST_RSP;
                ST_RSP:
                begin
                    state_r     <= ST_IDLE;
                    cmd_ready_o <= 1'b1;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Filter bank state: symbolic code and raw control byte
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            filter_ctrl_o <= {bab_pkg::CHAN_CNT{bab_pkg::FLT_RAW_RESET}};
            code_r        <= {bab_pkg::CHAN_CNT{bab_pkg::FLT_CODE_RESET}};
        end
        else if (take && legal)
        begin
            if (cmd_i.op == bab_pkg::BAB_OP_FLT_SEL)
            begin
                // Raw byte follows the code so the read-back stays coherent
                code_r[ch]        <= cmd_i.value[3:0];
                filter_ctrl_o[ch] <= {4'h0, cmd_i.value[3:0]};
            end
            else if (cmd_i.op == bab_pkg::BAB_OP_RAW_WR)
                filter_ctrl_o[ch] <= cmd_i.value[7:0];
        end
    end

    // ------------------------------------------------------------
    // Antenna lines: only the named lines change
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            array_line_o <= {bab_pkg::CHAN_CNT{bab_pkg::LINES_RESET}};
        else if (take && legal && cmd_i.op == bab_pkg::BAB_OP_LINE_SET)
            array_line_o[ch] <= (array_line_o[ch] & ~cmd_i.line_mask)
                              | (cmd_i.line_val & cmd_i.line_mask);
    end

    // ------------------------------------------------------------
    // Bias loop: enable, DAC target or amps target
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            bias_loop_en_o   <= 4'h0;
            bias_dac_o       <= {bab_pkg::CHAN_CNT{bab_pkg::DAC_RESET}};
            bias_amps_o      <= '0;
            bias_amps_mode_o <= 4'h0;
        end
        else if (take && legal)
        begin
            case (cmd_i.op)
                bab_pkg::BAB_OP_LOOP:
                    bias_loop_en_o[ch] <= cmd_i.value[0];
                bab_pkg::BAB_OP_DAC_SET:
                begin
                    bias_dac_o[ch]       <= cmd_i.value[11:0];
                    bias_amps_mode_o[ch] <= 1'b0;
                end
                bab_pkg::BAB_OP_CUR_SET:
                begin
                    // The loop converts amps to its own target
                    bias_amps_o[ch]      <= cmd_i.value;
                    bias_amps_mode_o[ch] <= 1'b1;
                end
                default:
                    bias_loop_en_o <= bias_loop_en_o;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Reply: data then OK, or error alone
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_o       <= '0;
        end
        else if (take)
        begin
            rsp_valid_o    <= !(legal && cmd_i.op == bab_pkg::BAB_OP_SPI_XFER);
            rsp_o          <= '0;
            rsp_o.ok       <= legal;
            rsp_o.err      <= !legal;
            rsp_o.has_data <= legal;
            case (cmd_i.op)
                bab_pkg::BAB_OP_FLT_QRY:   rsp_o.data <= 64'(code_r[ch]);
                bab_pkg::BAB_OP_RAW_RD:    rsp_o.data <= 64'(filter_ctrl_o[ch]);
                bab_pkg::BAB_OP_LINE_QRY:  rsp_o.data <= 64'(array_line_o[ch]);
                bab_pkg::BAB_OP_DAC_QRY:   rsp_o.data <= 64'(bias_dac_o[ch]);
                bab_pkg::BAB_OP_CUR_QRY:   rsp_o.data <= 64'(meas_i[ch].current);
                bab_pkg::BAB_OP_GATE_QRY:  rsp_o.data <= 64'(meas_i[ch].gate_volt);
                bab_pkg::BAB_OP_DRAIN_QRY: rsp_o.data <= 64'(meas_i[ch].drain_volt);
                default:                   rsp_o.has_data <= 1'b0;
            endcase
        end
        else if (state_r == ST_SPI && spi_done)
        begin
            rsp_valid_o    <= 1'b1;
            rsp_o.data     <= spi_rx;
            rsp_o.spi_cnt  <= cmd_r.spi_cnt;
            rsp_o.has_data <= 1'b1;
        end
        else
            rsp_valid_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // A legal command taken at this edge; the checks below add the opcode
    sequence s_legal_take;
        take && legal;
    endsequence

    // Shifter reports the end of a frame while the engine waits on it
    sequence s_xfer_end;
        state_r == ST_SPI && spi_done;
    endsequence

    // Refusal must leave the filter byte, lines, DAC, loop enable and amps target untouched
    a_reject_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        take && !legal |=> $stable(filter_ctrl_o) && $stable(array_line_o) && $stable(bias_dac_o)
            && $stable(bias_loop_en_o) && $stable(bias_amps_o))
        else $error("illegal command changed state");

    a_ok_reply: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_legal_take ##0 (cmd_i.op != bab_pkg::BAB_OP_SPI_XFER)
        |=> rsp_valid_o && rsp_o.ok && !rsp_o.err)
        else $error("accepted command without OK");

    a_line_set: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_legal_take ##0 (cmd_i.op == bab_pkg::BAB_OP_LINE_SET)
        |=> (array_line_o[$past(ch)] & $past(cmd_i.line_mask))
            == ($past(cmd_i.line_val) & $past(cmd_i.line_mask)))
        else $error("line set not applied");

    a_dac_apply: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_legal_take ##0 (cmd_i.op == bab_pkg::BAB_OP_DAC_SET)
        |=> bias_dac_o[$past(ch)] == $past(cmd_i.value[11:0]))
        else $error("dac setpoint not applied");

    a_loop_apply: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_legal_take ##0 (cmd_i.op == bab_pkg::BAB_OP_LOOP)
        |=> bias_loop_en_o[$past(ch)] == $past(cmd_i.value[0]))
        else $error("loop enable not applied");

    a_raw_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_legal_take ##0 (cmd_i.op == bab_pkg::BAB_OP_RAW_WR)
        |=> filter_ctrl_o[$past(ch)] == $past(cmd_i.value[7:0]))
        else $error("raw filter write lost");

    a_chan_range: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        take && cmd_i.chan[2] |=> rsp_o.err && !rsp_o.ok)
        else $error("bad channel not rejected");

    // Frame opens one edge after the start pulse, with no early reply
    a_xfer_start: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_legal_take ##0 (cmd_i.op == bab_pkg::BAB_OP_SPI_XFER)
        |=> !rsp_valid_o ##1 !array_cs_n_o)
        else $error("serial frame not opened");

    a_spi_count: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_xfer_end |=> rsp_valid_o && rsp_o.has_data && rsp_o.spi_cnt == cmd_r.spi_cnt)
        else $error("serial reply count wrong");

endmodule : bab_cmd_top

/* tb/bab_spi_slave.sv */
// Behavioural antenna-array serial device for the command engine bench.
// Assumes mode 0 framing: sample on sck rise, shift on sck fall.
`timescale 1ns/1ps
module bab_spi_slave (
    // Serial pins
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    // Bench side
    input  wire logic [63:0] reply_i,
    output logic [63:0]      got_o
);
    // ------------------------------------------------------------
    // Frame bookkeeping
    // ------------------------------------------------------------
    int   n;
    logic last = 1'b0;
    // Frame start clears the bit count and the captured bytes
    always @(negedge cs_n_i)
    begin
        n = 0;
        got_o = '0;
    end
    // Capture byte k into slot k, most significant bit first
    always @(posedge sck_i)
        if (!cs_n_i)
        begin
            got_o[(n/8)*8+7-n%8] <= mosi_i;
            last                 <= miso_o;
        end
    always @(negedge sck_i)
        if (!cs_n_i)
            n = n + 1;
    // Released line shows the inverse of its last bit, never a stale copy
    assign miso_o = cs_n_i ? ~last : reply_i[(n/8)*8+7-n%8];
endmodule : bab_spi_slave

/* tb/tb_top.sv */
// Self-checking bench for the command engine, with a reference model in arrays.
// Assumes the decoded command struct and reply layout of the package.
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst = 1, vld = 0, ptx = 1;
    bab_pkg::bab_cmd_s        c = '0;
    bab_pkg::bab_rsp_s        rsp;
    bab_pkg::bab_meas_s [3:0] meas = '0;
    logic [15:0] lim = bab_pkg::CUR_LIMIT_DEF;
    logic rdy, rv, sck, csn, mosi, miso;
    logic [3:0][7:0]  fc;
    logic [3:0][3:0]  ln;
    logic [3:0]       lpo, amo;
    logic [3:0][11:0] dco;
    logic [3:0][15:0] amo16;
    logic [63:0] rep = '0, got;
    logic [7:0]  raw[4] = '{default: 8'h00};
    logic [3:0]  flt[4] = '{default: 4'h7}, lin[4] = '{default: 4'h0};
    logic        lp[4] = '{default: 1'b0}, am[4] = '{default: 1'b0};
    logic [11:0] dac[4] = '{default: 12'h000};
    logic [15:0] amp[4] = '{default: 16'h0000};
    logic [31:0] s = 32'h4292;
    int failures = 0, checks_done = 0, i;
    always #2.5 clk = ~clk;
    bab_cmd_top u_dut (.core_clk_i(clk), .sys_rst_i(rst), .cmd_valid_i(vld), .cmd_i(c), .cur_limit_i(lim),
        .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_o(rsp), .meas_i(meas), .filter_ctrl_o(fc), .array_line_o(ln),
        .bias_loop_en_o(lpo), .bias_dac_o(dco), .bias_amps_o(amo16), .bias_amps_mode_o(amo),
        .array_sck_o(sck), .array_cs_n_o(csn), .array_mosi_o(mosi), .array_miso_i(miso));
    bab_spi_slave u_slv (.sck_i(sck), .cs_n_i(csn), .mosi_i(mosi), .miso_o(miso), .reply_i(rep), .got_o(got));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lf(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lf
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One command: model verdict, drive, wait bounded, compare reply and all state outputs
    task automatic cmd(input logic [3:0] op, input logic [2:0] ch, input logic [15:0] v, input logic [3:0] m,
                       input logic [3:0] sc, input logic [63:0] tx);
        int k;
        logic ok;
        logic [63:0] ed, mk;
        ok = ch < 4 && op < 14;
        mk = {64{1'b1}} >> (64 - 8 * sc);
        case (op)
            0: ok &= ptx && v < 8;
            1, 3: ok &= ptx;
            2: ok &= ptx && v < 256;
            4: ok &= m != 0;
            6: ok &= sc inside {[1:8]};
            7: ok &= v < 2;
            8: ok &= v < 16'h1000;
            10: ok &= v <= lim;
            default: ;
        endcase
        @(negedge clk);
        c = '{bab_pkg::bab_op_e'(op), ch, ptx, v, m, v[3:0], sc, tx};
        vld = 1;
        for (k = 0; k < 20 && rdy !== 1'b1; k++) @(negedge clk);
        if (k == 20)
            failures++;
        @(negedge clk);
        vld = 0;
        for (k = 0; k < 4000 && rv !== 1'b1; k++) @(negedge clk);
        if (k == 4000)
        begin
            failures++;
            results();
        end
        chk("ok", ok, rsp.ok);
        chk("err", !ok, rsp.err);
        ed = '0;
        if (ok)
            case (op)
                0: begin flt[ch[1:0]] = v[3:0]; raw[ch[1:0]] = v[7:0]; end
                1: ed = flt[ch[1:0]];
                2: raw[ch[1:0]] = v[7:0];
                3: ed = raw[ch[1:0]];
                4: lin[ch[1:0]] = (lin[ch[1:0]] & ~m) | (v[3:0] & m);
                5: ed = lin[ch[1:0]];
                6: begin ed = rep & mk; chk("sent", tx & mk, got); chk("cnt", sc, rsp.spi_cnt); end
                7: lp[ch[1:0]] = v[0];
                8: begin dac[ch[1:0]] = v[11:0]; am[ch[1:0]] = 0; end
                9: ed = dac[ch[1:0]];
                10: begin amp[ch[1:0]] = v; am[ch[1:0]] = 1; end
                11: ed = meas[ch[1:0]].current;
                12: ed = meas[ch[1:0]].gate_volt;
                13: ed = meas[ch[1:0]].drain_volt;
                default: ;
            endcase
        if (ok && op inside {1, 3, 5, 6, 9, 11, 12, 13})
            chk("data", ed, op == 12 ? {48'h0, rsp.data[15:0]} : rsp.data);
        for (k = 0; k < 4; k++)
            chk("state", {raw[k], lin[k], lp[k], dac[k], amp[k], am[k]},
                {fc[k], ln[k], lpo[k], dco[k], amo16[k], amo[k]});
    endtask : cmd
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(negedge clk);
        rst = 0;
        cmd(1, 0, 0, 0, 0, 0);
        for (i = 0; i < 9; i++) begin s = lf(s); cmd(0, s[1:0], i, 0, 0, 0); cmd(1, s[1:0], 0, 0, 0, 0); end
        $display("test filter done");
        for (i = 0; i < 3; i++)
        begin
            s = lf(s);
            cmd(2, s[1:0], s[15:8], 0, 0, 0);
            cmd(3, s[1:0], 0, 0, 0, 0);
        end
        cmd(2, 1, 16'h0100, 0, 0, 0);
        cmd(3, 1, 0, 0, 0, 0);
        $display("test raw done");
        for (i = 0; i < 8; i++)
        begin
            s = lf(s);
            cmd(4, s[1:0], s[7:4], s[11:8], 0, 0);
            cmd(5, s[1:0], 0, 0, 0, 0);
        end
        $display("test lines done");
        for (i = 0; i < 10; i++) begin s = lf(s); rep = {s, lf(s)}; cmd(6, s[1:0], 0, 0, i, {lf(s), s}); end
        $display("test serial done");
        for (i = 0; i < 3; i++) cmd(7, i, i, 0, 0, 0);
        cmd(8, 2, 16'h0fff, 0, 0, 0);
        cmd(9, 2, 0, 0, 0, 0);
        cmd(8, 2, 16'h1000, 0, 0, 0);
        cmd(10, 3, lim, 0, 0, 0);
        cmd(10, 3, lim + 16'h1, 0, 0, 0);
        for (i = 0; i < 4; i++) begin s = lf(s); meas[i] = {s, s[23:8]}; end
        for (i = 11; i < 14; i++) cmd(i, 3, 0, 0, 0, 0);
        $display("test bias done");
        for (i = 4; i < 8; i++) cmd(9, i, 0, 0, 0, 0);
        ptx = 0;
        cmd(0, 0, 3, 0, 0, 0);
        ptx = 1;
        cmd(14, 0, 0, 0, 0, 0);
        $display("test refusals done");
        results();
    end
endmodule : tb_top
